/* pkg/arc_consts.vh */
// Register map, field positions, reset values and codes for the converter
// register block. Included by every design file; holds definitions only.
`ifndef ARC_CONSTS_VH
`define ARC_CONSTS_VH

// Byte offsets of the registers on the register bus.
`define ARC_OFS_RES_HIGH   8'h00
`define ARC_OFS_RES_LOW    8'h04
`define ARC_OFS_CV_HIGH    8'h08
`define ARC_OFS_CV_LOW     8'h0C
`define ARC_OFS_CFG        8'h10
`define ARC_OFS_PIN_CTL    8'h14
`define ARC_OFS_CMP_CTL    8'h18
`define ARC_OFS_STATUS     8'h1C

// Internal register select codes.
`define ARC_SEL_NONE       3'h0
`define ARC_SEL_RES_HIGH   3'h1
`define ARC_SEL_RES_LOW    3'h2
`define ARC_SEL_CV_HIGH    3'h3
`define ARC_SEL_CV_LOW     3'h4
`define ARC_SEL_CFG        3'h5
`define ARC_SEL_PIN_CTL    3'h6
`define ARC_SEL_CMP_CTL    3'h7

// Configuration register fields.
`define ARC_CFG_LOW_POWER  7
`define ARC_CFG_DIV_HI     6
`define ARC_CFG_DIV_LO     5
`define ARC_CFG_LONG_SMP   4
`define ARC_CFG_MODE_HI    3
`define ARC_CFG_MODE_LO    2
`define ARC_CFG_CLK_HI     1
`define ARC_CFG_CLK_LO     0

// Compare control register fields.
`define ARC_CMP_ENABLE     0
`define ARC_CMP_GREATER    1

// Status register fields.
`define ARC_ST_LOCKED      0
`define ARC_ST_VALID       1

// Conversion width codes.
`define ARC_MODE_8BIT      2'h0
`define ARC_MODE_10BIT     2'h2

// Input clock source codes.
`define ARC_CLK_BUS        2'h0
`define ARC_CLK_BUS_HALF   2'h1
`define ARC_CLK_ALT        2'h2
`define ARC_CLK_ASYNC      2'h3

// Clock divide codes.
`define ARC_DIV_1          2'h0
`define ARC_DIV_2          2'h1
`define ARC_DIV_4          2'h2
`define ARC_DIV_8          2'h3

// Reset values.
`define ARC_RST_BYTE       8'h00
`define ARC_RST_CMP_CTL    2'h0

// AXI4-Lite response codes.
`define ARC_RESP_OKAY      2'h0
`define ARC_RESP_SLVERR    2'h2

`endif

/* verif/arc_host_model.sv */
// Processor-side AXI4-Lite master that reaches the register block.
// Changes its signals just after rising edges; waits are ended only by
// the bench timeout. Released address and data lines show inverted values.
module arc_host_model
(
    input  wire logic        i_core_clk,
    output logic [7:0]  i_awaddr,
    output logic        i_awvalid,
    input  wire logic        o_awready,
    output logic [31:0] i_wdata,
    output logic [3:0]  i_wstrb,
    output logic        i_wvalid,
    input  wire logic        o_wready,
    input  wire logic [1:0]  o_bresp,
    input  wire logic        o_bvalid,
    output logic        i_bready,
    output logic [7:0]  i_araddr,
    output logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire logic [31:0] o_rdata,
    input  wire logic [1:0]  o_rresp,
    input  wire logic        o_rvalid,
    output logic        i_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero; every byte lane is always offered.
    initial
    begin
        {i_awaddr, i_awvalid, i_wdata, i_wvalid, i_bready} = '0;
        {i_araddr, i_arvalid, i_rready} = '0;
        i_wstrb = 4'hF;
    end

    // Address and data go out together and are released separately.
    task write(input [7:0] a, input [31:0] d, output [1:0] r);
        @(posedge i_core_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        fork
            begin
                do @(posedge i_core_clk); while (o_awready !== 1'b1);
                i_awvalid <= 1'b0;
                i_awaddr <= ~a;
            end
            begin
                do @(posedge i_core_clk); while (o_wready !== 1'b1);
                i_wvalid <= 1'b0;
                i_wdata <= ~d;
            end
        join
        do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
        r = o_bresp;
        i_bready <= 1'b0;
    endtask

    // Read data is taken at the edge where rvalid is seen with rready.
    task read(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge i_core_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_core_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        i_araddr <= ~a;
        do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask
endmodule

/* verif/arc_regs_properties.sv */
// Port checker for the converter register block, bound to arc_regs.
// Assumes one clock, i_core_clk, and the synchronous reset i_rst_b.
module arc_regs_properties
(
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        i_conv_done,
    input wire logic        o_mode_10bit,
    input wire logic        o_result_valid,
    input wire logic [7:0]  i_port_read_data,
    input wire logic [7:0]  o_port_read_data,
    input wire logic [7:0]  o_pin_output_disable,
    input wire logic [7:0]  o_pin_input_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks share the core clock and drop out during reset.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // Read answers come one edge after the take; read and write answers stand until taken.
    read_latency_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer not one cycle after take");
    read_hold_a: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata)) else $error("read data moved");
    write_hold_a: assert property (o_bvalid && !i_bready
        |=> o_bvalid && $stable(o_bresp)) else $error("write answer moved");
    read_busy_a: assert property (o_rvalid |-> !o_arready)
        else $error("read taken while answer pending");
    read_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");

    // Released pins lose output and input together and read back as zero.
    pin_mirror_a: assert property (o_pin_output_disable == o_pin_input_disable)
        else $error("pin disables disagree");
    port_mask_a: assert property ($past(i_rst_b) |->
        o_port_read_data == ($past(i_port_read_data) & ~o_pin_input_disable))
        else $error("released pin read not zero");

    // The low byte becomes valid only from a completion, never from a write.
    valid_rise_a: assert property ($rose(o_result_valid) |-> $past(i_conv_done))
        else $error("result valid without completion");
    width_clear_a: assert property ($changed(o_mode_10bit)
        |-> !o_result_valid || $past(i_conv_done))
        else $error("low byte still valid after width change");

    cover property (o_rvalid && i_rready);
    cover property (i_conv_done && o_mode_10bit);
    cover property ($fell(o_result_valid));
endmodule

bind arc_regs arc_regs_properties u_props (.*);

/* verif/tb_top.sv */
// Self-checking bench for arc_regs with the host model on its bus.
// Assumes a 250 MHz core clock and the header arc_consts.vh on the path.
`include "arc_consts.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk, i_rst_b, i_awvalid, i_wvalid, i_bready;
    logic        i_arvalid, i_rready, i_conv_done, i_alt_clk_tick;
    logic        i_async_clk_tick, o_awready, o_wready, o_bvalid;
    logic        o_arready, o_rvalid, o_conv_clk_tick, o_low_power;
    logic        o_long_sample, o_mode_10bit, o_result_valid;
    logic [1:0]  o_bresp, o_rresp, rs;
    logic [3:0]  i_wstrb;
    logic [7:0]  i_awaddr, i_araddr, i_port_read_data, o_port_read_data;
    logic [7:0]  o_pin_output_disable, o_pin_input_disable, last, v;
    logic [7:0]  o_pin_pullup_disable;
    logic [9:0]  i_conv_result, r, cv;
    logic [31:0] i_wdata, o_rdata, rdat;
    logic [7:0]  ofs [4] = '{`ARC_OFS_CV_HIGH, `ARC_OFS_CV_LOW,
                             `ARC_OFS_CFG, `ARC_OFS_PIN_CTL};
    logic [7:0]  msk [4] = '{8'h03, 8'hFF, 8'hFF, 8'hFF};
    int          errors = 0, checks = 0, cycles = 0, n, want;
    integer      seed = 32'h9330;

    arc_regs u_arc_regs (.*);
    arc_host_model u_arc_host_model (.*);

    // Core clock of 4 ns.
    always #2 i_core_clk = ~i_core_clk;

    // Free-running clock sources at half rate, random pins, hang limit.
    always @(posedge i_core_clk)
    begin
        i_alt_clk_tick <= cycles[0];
        i_async_clk_tick <= !cycles[0];
        i_port_read_data <= $random(seed);
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            complete_run();
        end
    end

    task complete_run;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        u_arc_host_model.write(a, d, rs);
        `CHK(rs, er)
    endtask

    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        u_arc_host_model.read(a, rdat, rs);
        `CHK(rdat, e)
        `CHK(rs, er)
    endtask

    // One-cycle completion; the result lines go stale afterwards.
    task conv(input [9:0] x);
        @(posedge i_core_clk);
        i_conv_done <= 1'b1;
        i_conv_result <= x;
        @(posedge i_core_clk);
        i_conv_done <= 1'b0;
        i_conv_result <= ~x;
    endtask

    // Whether a completion with compare on is stored.
    function logic loads(input [9:0] x, input [9:0] c, input gt, input m);
        logic lt;
        lt = m ? (x < c) : (x[7:0] < c[7:0]);
        return gt ? !lt : lt;
    endfunction

    initial
    begin
        {i_core_clk, i_rst_b, i_conv_done, i_conv_result} = '0;
        repeat (16) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd(ofs[i], 32'h0, `ARC_RESP_OKAY);
        rd(`ARC_OFS_CMP_CTL, 32'h0, `ARC_RESP_OKAY);
        // Random register traffic, width code kept to a legal value.
        repeat (3) for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            if (i == 2)
                v[2] = 1'b0;
            wr(ofs[i], {24'h0, v}, `ARC_RESP_OKAY);
            rd(ofs[i], {24'h0, v & msk[i]}, `ARC_RESP_OKAY);
            if (i == 2)
                `CHK({o_low_power, o_long_sample, o_mode_10bit}, {v[7], v[4], v[3]})
            if (i == 3)
                `CHK(o_pin_pullup_disable, v)
        end
        wr(8'h20, 32'h5A, `ARC_RESP_SLVERR);
        wr(`ARC_OFS_RES_LOW, 32'h5A, `ARC_RESP_SLVERR);
        rd(8'h20, 32'h0, `ARC_RESP_SLVERR);
        // 8-bit: no interlock, upper bits read zero.
        wr(`ARC_OFS_CFG, 32'h0, `ARC_RESP_OKAY);
        wr(`ARC_OFS_CMP_CTL, 32'h0, `ARC_RESP_OKAY);
        conv($random(seed));
        rd(`ARC_OFS_RES_HIGH, 32'h0, `ARC_RESP_OKAY);
        r = $random(seed);
        conv(r);
        rd(`ARC_OFS_RES_LOW, r[7:0], `ARC_RESP_OKAY);
        // 10-bit: a high read locks out the next completion.
        wr(`ARC_OFS_CFG, 32'h08, `ARC_RESP_OKAY);
        r = $random(seed);
        conv(r);
        rd(`ARC_OFS_RES_HIGH, r[9:8], `ARC_RESP_OKAY);
        rd(`ARC_OFS_STATUS, 32'h3, `ARC_RESP_OKAY);
        conv(~r);
        rd(`ARC_OFS_RES_LOW, r[7:0], `ARC_RESP_OKAY);
        conv(~r);
        rd(`ARC_OFS_RES_LOW, {24'h0, ~r[7:0]}, `ARC_RESP_OKAY);
        wr(`ARC_OFS_CFG, 32'h0, `ARC_RESP_OKAY);
        rd(`ARC_OFS_RES_LOW, 32'h0, `ARC_RESP_OKAY);
        rd(`ARC_OFS_RES_HIGH, 32'h0, `ARC_RESP_OKAY);
        // Compare in both widths and both senses, equality included.
        for (int k = 0; k < 4; k++)
        begin
            wr(`ARC_OFS_CFG, k[1] ? 32'h08 : 32'h0, `ARC_RESP_OKAY);
            wr(`ARC_OFS_CMP_CTL, 32'h0, `ARC_RESP_OKAY);
            last = $random(seed);
            conv({2'h0, last});
            cv = $random(seed);
            wr(`ARC_OFS_CV_HIGH, cv[9:8], `ARC_RESP_OKAY);
            wr(`ARC_OFS_CV_LOW, cv[7:0], `ARC_RESP_OKAY);
            wr(`ARC_OFS_CMP_CTL, {k[0], 1'b1}, `ARC_RESP_OKAY);
            for (int j = 0; j < 6; j++)
            begin
                r = (j == 0) ? cv : $random(seed);
                conv(r);
                if (loads(r, cv, k[0], k[1]))
                    last = r[7:0];
                rd(`ARC_OFS_RES_LOW, last, `ARC_RESP_OKAY);
            end
        end
        // Conversion clock rate for every source and divider.
        for (int k = 0; k < 16; k++)
        begin
            wr(`ARC_OFS_CFG, {k[3:2], 3'h0, k[1:0]}, `ARC_RESP_OKAY);
            repeat (16) @(posedge i_core_clk);
            n = 0;
            repeat (256) @(posedge i_core_clk) n += (o_conv_clk_tick === 1'b1);
            want = 256 / ((1 << k[3:2]) * ((k[1:0] == 0) ? 1 : 2));
            `CHK(n >= want - 1 && n <= want + 1, 1'b1)
        end
        // A second reset in mid-run restores the defaults.
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rd(`ARC_OFS_CFG, 32'h0, `ARC_RESP_OKAY);
        complete_run();
    end
endmodule

/* verilog/arc_clock_div.v */
// Conversion clock generator: picks one of four source ticks and divides
// it by 1, 2, 4 or 8. Sources other than the bus clock arrive as one-cycle
// enable ticks synchronous to the core clock.
`include "arc_consts.vh"

module arc_clock_div
(
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    input  wire [1:0] i_src_sel,
    input  wire [1:0] i_div_sel,
    input  wire       i_alt_tick,
    input  wire       i_async_tick,
    output reg        o_conv_tick
);

    reg       half_phase;
    reg [2:0] div_count;
    reg       src_tick;
    reg [2:0] div_last;

    // Source selection; the halved bus clock fires every second cycle.
    always @*
    begin
        case (i_src_sel)
            `ARC_CLK_BUS:      src_tick = 1'b1;
            `ARC_CLK_BUS_HALF: src_tick = half_phase;
            `ARC_CLK_ALT:      src_tick = i_alt_tick;
            default:           src_tick = i_async_tick;
        endcase
        case (i_div_sel)
            `ARC_DIV_1: div_last = 3'h0;
            `ARC_DIV_2: div_last = 3'h1;
            `ARC_DIV_4: div_last = 3'h3;
            default:    div_last = 3'h7;
        endcase
    end

    // Divider counter; a larger count left over after the divide ratio
    // shrinks wraps at once rather than running the full counter range.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            half_phase  <= 1'b0;
            div_count   <= 3'h0;
            o_conv_tick <= 1'b0;
        end
        else
        begin
            half_phase  <= ~half_phase;
            o_conv_tick <= 1'b0;
            if (src_tick)
            begin
                if (div_count >= div_last)
                begin
                    div_count   <= 3'h0;
                    o_conv_tick <= 1'b1;
                end
                else
                    div_count <= div_count + 3'h1;
            end
        end
    end

endmodule

/* verilog/arc_compare.v */
// Compare unit: decides whether a finished conversion satisfies the
// programmed compare condition. Purely combinational; the caller samples
// the answer in the cycle in which the conversion completes.
`include "arc_consts.vh"

module arc_compare
(
    input  wire [9:0] i_result,
    input  wire [1:0] i_cv_high,
    input  wire [7:0] i_cv_low,
    input  wire       i_mode_10bit,
    input  wire       i_greater,
    output reg        o_match
);

    reg [9:0] value_res;
    reg [9:0] value_cmp;

    // In 8-bit mode the upper compare bits are forced out of the comparison so
    // that stale high compare bits never affect the decision.
    always @*
    begin
        if (i_mode_10bit)
        begin
            value_res = i_result;
            value_cmp = {i_cv_high, i_cv_low};
        end
        else
        begin
            value_res = {2'h0, i_result[7:0]};
            value_cmp = {2'h0, i_cv_low};
        end
        if (i_greater)
            o_match = (value_res >= value_cmp);
        else
            o_match = (value_res < value_cmp);
    end

endmodule

/* verilog/arc_regs.v */
// Register block of a successive-approximation converter: result bytes
// with read interlock in 10-bit mode, compare values, configuration and pin control,
// reached over an AXI4-Lite slave port.
// Assumes the converter core pulses i_conv_done for one core clock with
// i_conv_result valid in that cycle, and that all inputs are synchronous.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`include "arc_consts.vh"

module arc_regs
(
    input  wire        i_core_clk,
    input  wire        i_rst_b,
    // AXI4-Lite slave.
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Converter core side.
    input  wire        i_conv_done,
    input  wire [9:0]  i_conv_result,
    input  wire        i_alt_clk_tick,
    input  wire        i_async_clk_tick,
    output reg         o_conv_clk_tick,
    output reg         o_low_power,
    output reg         o_long_sample,
    output reg         o_mode_10bit,
    output reg         o_result_valid,
    // Pin side.
    input  wire [7:0]  i_port_read_data,
    output reg  [7:0]  o_port_read_data,
    output reg  [7:0]  o_pin_output_disable,
    output reg  [7:0]  o_pin_input_disable,
    output reg  [7:0]  o_pin_pullup_disable
);

    // Register storage.
    reg [1:0]  result_high_bits;
    reg [7:0]  result_low_byte;
    reg [1:0]  compare_value_high;
    reg [7:0]  compare_value_low;
    reg [7:0]  converter_configuration;
    reg [7:0]  analog_pin_control_low;
    reg        compare_function_enable;
    reg        compare_greater_select;
    reg        result_locked;

    // Write channel holding registers.
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    wire       cmp_match;
    wire       conv_tick;
    wire       mode_10bit;
    wire       wr_fire;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire       rd_fire;
    wire       load_result;
    wire       mode_change;
    reg  [7:0] next_cfg;
    reg  [7:0] rd_byte;

    // Maps a byte address to a register select; anything else is unmapped.
    function [2:0] f_reg_sel;
        input [7:0] addr;
        begin
            if (addr == `ARC_OFS_RES_HIGH)
                f_reg_sel = `ARC_SEL_RES_HIGH;
            else if (addr == `ARC_OFS_RES_LOW)
                f_reg_sel = `ARC_SEL_RES_LOW;
            else if (addr == `ARC_OFS_CV_HIGH)
                f_reg_sel = `ARC_SEL_CV_HIGH;
            else if (addr == `ARC_OFS_CV_LOW)
                f_reg_sel = `ARC_SEL_CV_LOW;
            else if (addr == `ARC_OFS_CFG)
                f_reg_sel = `ARC_SEL_CFG;
            else if (addr == `ARC_OFS_PIN_CTL)
                f_reg_sel = `ARC_SEL_PIN_CTL;
            else if (addr == `ARC_OFS_CMP_CTL)
                f_reg_sel = `ARC_SEL_CMP_CTL;
            else
                f_reg_sel = `ARC_SEL_NONE;
        end
    endfunction

    // The status word is decoded separately because it has no storage.
    function f_is_status;
        input [7:0] addr;
        begin
            f_is_status = (addr == `ARC_OFS_STATUS);
        end
    endfunction

    assign mode_10bit = (converter_configuration[`ARC_CFG_MODE_HI:
                         `ARC_CFG_MODE_LO] == `ARC_MODE_10BIT);
    assign wr_fire = aw_held && w_held && !o_bvalid;
    assign wr_sel  = f_reg_sel(aw_addr);
    assign rd_fire = i_arvalid && o_arready;
    assign rd_sel  = f_reg_sel(i_araddr);

    // A completion is kept only when compare passes (or is off) and the
    // lock from a high-byte read is not in force.
    assign load_result = i_conv_done
                         && (!compare_function_enable || cmp_match)
                         && !(result_locked && mode_10bit);

    arc_compare u_compare
    (
        .i_result     (i_conv_result),
        .i_cv_high    (compare_value_high),
        .i_cv_low     (compare_value_low),
        .i_mode_10bit (mode_10bit),
        .i_greater    (compare_greater_select),
        .o_match      (cmp_match)
    );

    arc_clock_div u_clock_div
    (
        .i_core_clk   (i_core_clk),
        .i_rst_b      (i_rst_b),
        .i_src_sel    (converter_configuration[`ARC_CFG_CLK_HI:
                       `ARC_CFG_CLK_LO]),
        .i_div_sel    (converter_configuration[`ARC_CFG_DIV_HI:
                       `ARC_CFG_DIV_LO]),
        .i_alt_tick   (i_alt_clk_tick),
        .i_async_tick (i_async_clk_tick),
        .o_conv_tick  (conv_tick)
    );

    // Next configuration value and whether the width field moves with it.
    always @*
    begin
        next_cfg = converter_configuration;
        if (wr_fire && wr_sel == `ARC_SEL_CFG && w_strb[0])
            next_cfg = w_data[7:0];
    end
    assign mode_change = (next_cfg[`ARC_CFG_MODE_HI:`ARC_CFG_MODE_LO] !=
        converter_configuration[`ARC_CFG_MODE_HI:`ARC_CFG_MODE_LO]);

    // Write address and data are caught independently, in either order.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            aw_held   <= 1'b0;
            aw_addr   <= 8'h00;
            w_held    <= 1'b0;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `ARC_RESP_OKAY;
        end
        else
        begin
            o_awready <= !aw_held && !(i_awvalid && o_awready);
            o_wready  <= !w_held && !(i_wvalid && o_wready);
            if (i_awvalid && o_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (wr_fire)
            begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                o_bvalid <= 1'b1;
                // Result and status words are read only.
                if (wr_sel == `ARC_SEL_NONE || wr_sel == `ARC_SEL_RES_HIGH
                    || wr_sel == `ARC_SEL_RES_LOW)
                    o_bresp <= `ARC_RESP_SLVERR;
                else
                    o_bresp <= `ARC_RESP_OKAY;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Writable registers; a byte lane that is not strobed is left alone.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            compare_value_high      <= 2'h0;
            compare_value_low       <= `ARC_RST_BYTE;
            converter_configuration <= `ARC_RST_BYTE;
            analog_pin_control_low  <= `ARC_RST_BYTE;
            compare_function_enable <= 1'b0;
            compare_greater_select  <= 1'b0;
        end
        else
        begin
            converter_configuration <= next_cfg;
            if (wr_fire && w_strb[0])
            begin
                if (wr_sel == `ARC_SEL_CV_HIGH)
                    compare_value_high <= w_data[1:0];
                else if (wr_sel == `ARC_SEL_CV_LOW)
                    compare_value_low <= w_data[7:0];
                else if (wr_sel == `ARC_SEL_PIN_CTL)
                    analog_pin_control_low <= w_data[7:0];
                else if (wr_sel == `ARC_SEL_CMP_CTL)
                begin
                    compare_function_enable <= w_data[`ARC_CMP_ENABLE];
                    compare_greater_select  <= w_data[`ARC_CMP_GREATER];
                end
            end
        end
    end

    // Result capture, lock and validity. A completion in the same cycle
    // as a width change wins, so a fresh result is never marked stale.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            result_high_bits <= 2'h0;
            result_low_byte  <= `ARC_RST_BYTE;
            result_locked    <= 1'b0;
            o_result_valid   <= 1'b0;
        end
        else
        begin
            if (load_result)
            begin
                if (mode_10bit)
                    result_high_bits <= i_conv_result[9:8];
                else
                    result_high_bits <= 2'h0;
                result_low_byte <= i_conv_result[7:0];
                o_result_valid  <= 1'b1;
            end
            else if (mode_change)
                o_result_valid <= 1'b0;
            // The lock only arms in 10-bit mode; 8-bit reads never lock.
            if (rd_fire && rd_sel == `ARC_SEL_RES_LOW)
                result_locked <= 1'b0;
            else if (rd_fire && rd_sel == `ARC_SEL_RES_HIGH && mode_10bit)
                result_locked <= 1'b1;
            else if (!mode_10bit)
                result_locked <= 1'b0;
        end
    end

    // Read data selection for the addressed word.
    always @*
    begin
        rd_byte = 8'h00;
        if (rd_sel == `ARC_SEL_RES_HIGH)
            rd_byte = {6'h00, mode_10bit ? result_high_bits : 2'h0};
        else if (rd_sel == `ARC_SEL_RES_LOW)
            rd_byte = o_result_valid ? result_low_byte : 8'h00;
        else if (rd_sel == `ARC_SEL_CV_HIGH)
            rd_byte = {6'h00, compare_value_high};
        else if (rd_sel == `ARC_SEL_CV_LOW)
            rd_byte = compare_value_low;
        else if (rd_sel == `ARC_SEL_CFG)
            rd_byte = converter_configuration;
        else if (rd_sel == `ARC_SEL_PIN_CTL)
            rd_byte = analog_pin_control_low;
        else if (rd_sel == `ARC_SEL_CMP_CTL)
            rd_byte = {6'h00, compare_greater_select,
                       compare_function_enable};
        else if (f_is_status(i_araddr))
            rd_byte = {6'h00, o_result_valid, result_locked};
    end

    // Read channel: one read at a time, answered in the cycle after the
    // address is taken; arready drops while the answer is pending.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `ARC_RESP_OKAY;
        end
        else
        begin
            if (rd_fire)
            begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rdata   <= {24'h000000, rd_byte};
                if (rd_sel == `ARC_SEL_NONE && !f_is_status(i_araddr))
                    o_rresp <= `ARC_RESP_SLVERR;
                else
                    o_rresp <= `ARC_RESP_OKAY;
            end
            else if (o_rvalid && i_rready)
            begin
                o_rvalid  <= 1'b0;
                o_arready <= 1'b1;
            end
            else if (!o_rvalid)
                o_arready <= 1'b1;
        end
    end

    // Configuration and pin outputs, registered so the core and the pad
    // ring see clean levels one cycle after a register write.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_conv_clk_tick      <= 1'b0;
            o_low_power          <= 1'b0;
            o_long_sample        <= 1'b0;
            o_mode_10bit         <= 1'b0;
            o_port_read_data     <= 8'h00;
            o_pin_output_disable <= 8'h00;
            o_pin_input_disable  <= 8'h00;
            o_pin_pullup_disable <= 8'h00;
        end
        else
        begin
            o_conv_clk_tick <= conv_tick;
            o_low_power   <=
                converter_configuration[`ARC_CFG_LOW_POWER];
            o_long_sample <=
                converter_configuration[`ARC_CFG_LONG_SMP];
            o_mode_10bit  <= mode_10bit;
            o_pin_output_disable <= analog_pin_control_low;
            o_pin_input_disable  <= analog_pin_control_low;
            o_pin_pullup_disable <= analog_pin_control_low;
            o_port_read_data <= i_port_read_data
                                & ~analog_pin_control_low;
        end
    end

endmodule
